// >>> hw/obq_regs.svh
`ifndef OBQ_REGS_SVH
`define OBQ_REGS_SVH

// Query space layout, word addresses in the word-addressed query space
`define OBQ_QUERY_BASE      16'h010a
`define OBQ_FIRST_OFS       16'h000e
`define OBQ_LAST_OFS        16'h0021
`define OBQ_SYNC_FIRST_OFS  16'h001f
`define OBQ_SYNC_LAST_OFS   16'h0021

// Table memory geometry
`define OBQ_MEM_AW          5
`define OBQ_MEM_DEPTH       32
`define OBQ_TABLE_LAST_IDX  5'h13
`define OBQ_IDX_ZERO        5'h00
`define OBQ_IDX_ONE         5'h01
`define OBQ_IDX_STRAP       5'h02

// Absolute query addresses
`define OBQ_A_OTP_FIELDS    16'h0118
`define OBQ_A_OTP1_LO       16'h0119
`define OBQ_A_OTP1_HI       16'h011a
`define OBQ_A_OTP1_FACT     16'h011b
`define OBQ_A_OTP1_USER     16'h011c
`define OBQ_A_PROT2_B0      16'h011d
`define OBQ_A_USR_GRP_LO    16'h0124
`define OBQ_A_USR_GRP_EXP   16'h0126
`define OBQ_A_PAGE_SIZE     16'h0127
`define OBQ_A_SYNC_COUNT    16'h0128
`define OBQ_A_SYNC_CFG1     16'h0129
`define OBQ_A_SYNC_CFG2     16'h012a
`define OBQ_A_SYNC_CFG3     16'h012b

// Byte values
`define OBQ_V_OTP_FIELDS    8'h02
`define OBQ_V_OTP1_LO       8'h80
`define OBQ_V_OTP1_HI       8'h00
`define OBQ_V_OTP1_FACT     8'h03
`define OBQ_V_OTP1_USER     8'h03
`define OBQ_V_PROT2_B0      8'h89
`define OBQ_V_ZERO          8'h00
`define OBQ_V_USR_GRP_LO    8'h10
`define OBQ_V_USR_GRP_EXP   8'h04
`define OBQ_V_PAGE_NONMUX   8'h05
`define OBQ_V_PAGE_MUX      8'h00
`define OBQ_V_SYNC_COUNT    8'h03
`define OBQ_V_SYNC_CFG1     8'h02
`define OBQ_V_SYNC_CFG2     8'h03
`define OBQ_V_SYNC_CFG3     8'h07

// Sync configuration entry fields
`define OBQ_SYNC_CODE_W     3
`define OBQ_SYNC_CONT       3'h7
`define OBQ_WORDS_ZERO      16'h0000
`define OBQ_WORDS_ONE       16'h0001
`define OBQ_UPPER_ZERO      8'h00

`endif

// >>> hw/obq_pkg.sv
package obq_pkg;

    typedef logic [7:0]  obq_byte_type;
    typedef logic [15:0] obq_addr_type;

    typedef enum logic [1:0] {
        OBQ_FILL,
        OBQ_IDLE,
        OBQ_LOOKUP,
        OBQ_DELIVER
    } obq_state_type;

endpackage : obq_pkg

// >>> hw/obq_mem.sv
`include "obq_regs.svh"

module obq_mem (
    input  wire logic                      sys_clk_i,
    input  wire logic                      wr_en_i,
    input  wire logic [`OBQ_MEM_AW-1:0]    wr_addr_i,
    input  wire obq_pkg::obq_byte_type     wr_data_i,
    input  wire logic [`OBQ_MEM_AW-1:0]    rd_addr_i,
    output obq_pkg::obq_byte_type          rd_data_o
);

    obq_pkg::obq_byte_type store [`OBQ_MEM_DEPTH];

    // No reset on the array; entries 0 to 19 are filled before any read is served
    always_ff @(posedge sys_clk_i) begin
        if (wr_en_i) begin
            store[wr_addr_i] <= wr_data_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        rd_data_o <= store[rd_addr_i];
    end

endmodule : obq_mem

// >>> hw/obq_query_table.sv
`include "obq_regs.svh"

module obq_query_table (
    input  wire logic                   sys_clk_i,
    input  wire logic                   resetn_i,
    input  wire logic                   query_mode_i,
    input  wire logic                   rd_req_i,
    input  wire obq_pkg::obq_addr_type  rd_addr_i,
    input  wire logic                   mux_strap_i,
    output logic                        ready_o,
    output logic [15:0]                 data_o,
    output logic                        data_valid_o,
    output logic                        hit_o,
    output logic [15:0]                 burst_words_o,
    output logic                        burst_cont_o
);

    obq_pkg::obq_state_type         state;
    obq_pkg::obq_state_type         next_state;
    logic [`OBQ_MEM_AW-1:0]         fill_idx;
    logic                           mux_sync1;
    logic                           mux_sync2;
    logic                           mux_iface;
    obq_pkg::obq_addr_type          req_ofs;
    logic                           req_hit;
    logic                           req_sync;
    logic                           look_hit;
    logic                           look_sync;
    obq_pkg::obq_byte_type          mem_rdata;
    obq_pkg::obq_byte_type          fill_data;

    // Offset from the query base; locations outside the table read zero
    function automatic obq_pkg::obq_addr_type base_ofs(input obq_pkg::obq_addr_type addr);
        base_ofs = addr - `OBQ_QUERY_BASE;
    endfunction : base_ofs

    function automatic logic ofs_in(input obq_pkg::obq_addr_type ofs,
                                    input obq_pkg::obq_addr_type lo,
                                    input obq_pkg::obq_addr_type hi);
        ofs_in = (ofs >= lo) && (ofs <= hi);
    endfunction : ofs_in

    // Constant byte for each table slot, slot 0 being the OTP field count
    function automatic obq_pkg::obq_byte_type table_byte(input logic [`OBQ_MEM_AW-1:0] idx,
                                                         input logic mux);
        obq_pkg::obq_addr_type addr;
        addr = `OBQ_QUERY_BASE + `OBQ_FIRST_OFS + {11'h000, idx};
        table_byte = `OBQ_V_ZERO;
        unique case (addr)
            `OBQ_A_OTP_FIELDS: table_byte = `OBQ_V_OTP_FIELDS;
            `OBQ_A_OTP1_LO:    table_byte = `OBQ_V_OTP1_LO;
            `OBQ_A_OTP1_HI:    table_byte = `OBQ_V_OTP1_HI;
            `OBQ_A_OTP1_FACT:  table_byte = `OBQ_V_OTP1_FACT;
            `OBQ_A_OTP1_USER:  table_byte = `OBQ_V_OTP1_USER;
            `OBQ_A_PROT2_B0:   table_byte = `OBQ_V_PROT2_B0;
            `OBQ_A_USR_GRP_LO: table_byte = `OBQ_V_USR_GRP_LO;
            `OBQ_A_USR_GRP_EXP: table_byte = `OBQ_V_USR_GRP_EXP;
            `OBQ_A_PAGE_SIZE:  table_byte = mux ? `OBQ_V_PAGE_MUX : `OBQ_V_PAGE_NONMUX;
            `OBQ_A_SYNC_COUNT: table_byte = `OBQ_V_SYNC_COUNT;
            `OBQ_A_SYNC_CFG1:  table_byte = `OBQ_V_SYNC_CFG1;
            `OBQ_A_SYNC_CFG2:  table_byte = `OBQ_V_SYNC_CFG2;
            `OBQ_A_SYNC_CFG3:  table_byte = `OBQ_V_SYNC_CFG3;
            default:           table_byte = `OBQ_V_ZERO;
        endcase
    endfunction : table_byte

    // Burst length in words; zero stands for an unbounded linear burst
    function automatic logic [15:0] burst_words(input logic [`OBQ_SYNC_CODE_W-1:0] code);
        if (code == `OBQ_SYNC_CONT) begin
            burst_words = `OBQ_WORDS_ZERO;
        end else begin
            burst_words = `OBQ_WORDS_ONE << (code + `OBQ_SYNC_CODE_W'(1));
        end
    endfunction : burst_words

    // Strap comes from a pin; two stages before use
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            mux_sync1 <= 1'b0;
            mux_sync2 <= 1'b0;
        end else begin
            mux_sync1 <= mux_strap_i;
            mux_sync2 <= mux_sync1;
        end
    end

    // Interface kind frozen once the second stage holds the strap sampled after release
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            mux_iface <= 1'b0;
        end else if (state == obq_pkg::OBQ_FILL && fill_idx == `OBQ_IDX_STRAP) begin
            mux_iface <= mux_sync2;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            fill_idx <= `OBQ_IDX_ZERO;
        end else if (state == obq_pkg::OBQ_FILL) begin
            fill_idx <= fill_idx + `OBQ_IDX_ONE;
        end
    end

    // Page size slot is filled long after the strap froze
    assign fill_data = table_byte(fill_idx, mux_iface);

    assign req_ofs = base_ofs(rd_addr_i);

    always_comb begin
        next_state = state;
        unique case (state)
            obq_pkg::OBQ_FILL: begin
                if (fill_idx == `OBQ_TABLE_LAST_IDX) begin
                    next_state = obq_pkg::OBQ_IDLE;
                end
            end
            obq_pkg::OBQ_IDLE: begin
                if (rd_req_i && query_mode_i) begin
                    next_state = obq_pkg::OBQ_LOOKUP;
                end
            end
            obq_pkg::OBQ_LOOKUP: begin
                next_state = obq_pkg::OBQ_DELIVER;
            end
            obq_pkg::OBQ_DELIVER: begin
                next_state = obq_pkg::OBQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            state <= obq_pkg::OBQ_FILL;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            ready_o <= 1'b0;
        end else begin
            ready_o <= (next_state == obq_pkg::OBQ_IDLE);
        end
    end

    // Request capture; memory index is the offset past the first table slot
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            req_hit  <= 1'b0;
            req_sync <= 1'b0;
            look_hit  <= 1'b0;
            look_sync <= 1'b0;
        end else begin
            if (state == obq_pkg::OBQ_IDLE && rd_req_i && query_mode_i) begin
                req_hit  <= ofs_in(req_ofs, `OBQ_FIRST_OFS, `OBQ_LAST_OFS);
                req_sync <= ofs_in(req_ofs, `OBQ_SYNC_FIRST_OFS, `OBQ_SYNC_LAST_OFS);
            end
            look_hit  <= req_hit;
            look_sync <= req_sync;
        end
    end

    logic [`OBQ_MEM_AW-1:0] req_idx;

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            req_idx <= `OBQ_IDX_ZERO;
        end else if (state == obq_pkg::OBQ_IDLE && rd_req_i && query_mode_i) begin
            req_idx <= `OBQ_MEM_AW'(req_ofs - `OBQ_FIRST_OFS);
        end
    end

    obq_mem u_mem (
        .sys_clk_i (sys_clk_i),
        .wr_en_i   (state == obq_pkg::OBQ_FILL),
        .wr_addr_i (fill_idx),
        .wr_data_i (fill_data),
        .rd_addr_i (req_idx),
        .rd_data_o (mem_rdata)
    );

    // byte on low lines, upper zero
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            data_o       <= {`OBQ_UPPER_ZERO, `OBQ_V_ZERO};
            data_valid_o <= 1'b0;
            hit_o        <= 1'b0;
        end else begin
            data_valid_o <= (state == obq_pkg::OBQ_DELIVER);
            if (state == obq_pkg::OBQ_DELIVER) begin
                data_o <= {`OBQ_UPPER_ZERO, look_hit ? mem_rdata : `OBQ_V_ZERO};
                hit_o  <= look_hit;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            burst_words_o <= `OBQ_WORDS_ZERO;
            burst_cont_o  <= 1'b0;
        end else if (state == obq_pkg::OBQ_DELIVER) begin
            if (look_hit && look_sync) begin
                burst_words_o <= burst_words(mem_rdata[`OBQ_SYNC_CODE_W-1:0]);
                burst_cont_o  <= (mem_rdata[`OBQ_SYNC_CODE_W-1:0] == `OBQ_SYNC_CONT);
            end else begin
                burst_words_o <= `OBQ_WORDS_ZERO;
                burst_cont_o  <= 1'b0;
            end
        end
    end

endmodule : obq_query_table

// >>> testbench/obq_props.sv
module obq_props (
    input wire logic                  sys_clk_i,
    input wire logic                  resetn_i,
    input wire logic                  query_mode_i,
    input wire logic                  rd_req_i,
    input wire obq_pkg::obq_addr_type rd_addr_i,
    input wire logic                  mux_strap_i,
    input wire logic                  ready_o,
    input wire logic [15:0]           data_o,
    input wire logic                  data_valid_o,
    input wire logic                  hit_o,
    input wire logic [15:0]           burst_words_o,
    input wire logic                  burst_cont_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        take;
    logic [15:0] last_addr;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);
    assign take = ready_o && rd_req_i && query_mode_i;
    // Remembers which location the pending answer belongs to
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i)
            last_addr <= 16'h0000;
        else if (take)
            last_addr <= rd_addr_i;
    end
    a_fixed_latency: assert property (take |=> !ready_o ##1 !ready_o ##1 data_valid_o)
        else $error("answer latency wrong");
    a_hit_range: assert property (data_valid_o |-> hit_o == (last_addr >= 16'h0118 && last_addr <= 16'h012b))
        else $error("hit flag wrong");
    a_miss_zero: assert property (data_valid_o && !hit_o |-> data_o == 16'h0000 && burst_words_o == 16'h0000)
        else $error("miss not zero");
    a_upper_zero: assert property (data_valid_o |-> data_o[15:8] == 8'h00 ##1 !data_valid_o)
        else $error("upper byte or pulse wrong");
    a_idle_holds: assert property (ready_o && !take |=> ready_o && !data_valid_o)
        else $error("ignored request changed state");
    a_otp_count: assert property (data_valid_o && last_addr == 16'h0118 |-> data_o == 16'h0002)
        else $error("field count wrong");
    a_otp_user: assert property (data_valid_o && last_addr == 16'h011c |-> data_o == 16'h0003)
        else $error("user exponent wrong");
    a_prot_word: assert property (data_valid_o && last_addr == 16'h011d |-> data_o == 16'h0089)
        else $error("lock word wrong");
    a_sync_count: assert property (data_valid_o && last_addr == 16'h0128 |-> data_o == 16'h0003)
        else $error("sync count wrong");
    a_sync_eight: assert property (data_valid_o && last_addr == 16'h0129 |-> burst_words_o == 16'h0008)
        else $error("burst eight wrong");
    a_sync_cont: assert property (data_valid_o && last_addr == 16'h012b |-> burst_cont_o && data_o == 16'h0007)
        else $error("continuous wrong");
endmodule : obq_props

bind obq_query_table obq_props i_props (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .query_mode_i(query_mode_i),
    .rd_req_i(rd_req_i), .rd_addr_i(rd_addr_i), .mux_strap_i(mux_strap_i), .ready_o(ready_o), .data_o(data_o),
    .data_valid_o(data_valid_o), .hit_o(hit_o), .burst_words_o(burst_words_o), .burst_cont_o(burst_cont_o));

// >>> testbench/obq_host_model.sv
module obq_host_model (
    input  wire logic            sys_clk_i,
    input  wire logic            ready_o,
    input  wire logic            data_valid_o,
    input  wire logic [15:0]     data_o,
    output obq_pkg::obq_addr_type rd_addr_o,
    output logic                 rd_req_o,
    output logic [2:0]           read_config_register
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        rd_req_o = 1'b0;
        rd_addr_o = 16'hffff;
        read_config_register = 3'h0;
    end
    // Entered just after a rising edge; request held until an edge sees ready
    task automatic read(input obq_pkg::obq_addr_type a, output logic [15:0] d, output int n);
        rd_addr_o = a;
        rd_req_o = 1'b1;
        n = 0;
        // Ready is looked at off the edge, where it has settled
        while (ready_o !== 1'b1 && n < 40) begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
        @(posedge sys_clk_i);
        #1;
        rd_req_o = 1'b0;
        // Released lines flip so a stale address never passes for a held one
        rd_addr_o = ~a;
        n = 0;
        while (data_valid_o !== 1'b1 && n < 8) begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
        d = data_o;
        if (a >= 16'h0129 && a <= 16'h012b)
            read_config_register = d[2:0];
    endtask : read
endmodule : obq_host_model

// >>> testbench/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  sys_clk_i;
    logic                  resetn_i;
    logic                  query_mode_i;
    logic                  mux_strap_i;
    logic                  rd_req_i;
    obq_pkg::obq_addr_type rd_addr_i;
    logic                  ready_o;
    logic                  data_valid_o;
    logic                  hit_o;
    logic                  burst_cont_o;
    logic [15:0]           data_o;
    logic [15:0]           burst_words_o;
    logic [2:0]            read_config_register;
    int                    err_total;
    int                    checks_done;
    logic [7:0]            exp_byte [0:19] = '{8'h02, 8'h80, 8'h00, 8'h03, 8'h03, 8'h89, 8'h00, 8'h00, 8'h00, 8'h00,
                                               8'h00, 8'h00, 8'h10, 8'h00, 8'h04, 8'h05, 8'h03, 8'h02, 8'h03, 8'h07};

    obq_query_table i_dut (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .query_mode_i(query_mode_i),
        .rd_req_i(rd_req_i), .rd_addr_i(rd_addr_i), .mux_strap_i(mux_strap_i), .ready_o(ready_o), .data_o(data_o),
        .data_valid_o(data_valid_o), .hit_o(hit_o), .burst_words_o(burst_words_o), .burst_cont_o(burst_cont_o));
    obq_host_model i_host (.sys_clk_i(sys_clk_i), .ready_o(ready_o), .data_valid_o(data_valid_o), .data_o(data_o),
        .rd_addr_o(rd_addr_i), .rd_req_o(rd_req_i), .read_config_register(read_config_register));

    always #5 sys_clk_i = ~sys_clk_i;

    task automatic check(input logic [15:0] seen, input logic [15:0] want, input string what);
        checks_done++;
        if (seen !== want) begin
            err_total++;
            $display("FAIL %0t %s seen %h want %h", $time, what, seen, want);
        end
    endtask : check

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test

    task automatic do_reset(input logic strap);
        int n;
        resetn_i = 1'b0;
        mux_strap_i = strap;
        repeat (2) @(posedge sys_clk_i);
        #1;
        check({ready_o, data_valid_o, hit_o, burst_cont_o, 12'h000}, 16'h0000, "flags in reset");
        resetn_i = 1'b1;
        n = 0;
        while (ready_o !== 1'b1 && n < 40) begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
        check({15'h0, ready_o}, 16'h0001, "ready after fill");
    endtask : do_reset

    // Every location in order, back to back
    task automatic t_table_sweep(input logic mux);
        logic [15:0] d;
        logic [15:0] want;
        logic [2:0]  code;
        int          n;
        for (int i = 0; i < 20; i++) begin
            i_host.read(16'h0118 + 16'(i), d, n);
            want = {8'h00, exp_byte[i]};
            if (i == 15 && mux)
                want = 16'h0000;
            code = exp_byte[i][2:0];
            check(d, want, "table byte");
            check(16'(n), 16'd2, "latency");
            check({15'h0, hit_o}, 16'h0001, "hit");
            check(burst_words_o, (i == 17) ? 16'h0008 : (i == 18) ? 16'h0010 : 16'h0000, "burst");
            check({15'h0, burst_cont_o}, {15'h0, i == 19}, "continuous");
            if (i >= 17)
                check({13'h0, read_config_register}, {13'h0, code}, "config copy");
        end
    endtask : t_table_sweep

    task automatic t_outside;
        logic [15:0]           d;
        int                    n;
        obq_pkg::obq_addr_type bad [3] = '{16'h010a, 16'h0117, 16'h012c};
        foreach (bad[k]) begin
            i_host.read(bad[k], d, n);
            check(d, 16'h0000, "outside data");
            check({15'h0, hit_o}, 16'h0000, "outside hit");
        end
    endtask : t_outside

    task automatic t_refused;
        logic [15:0] d;
        int          n;
        query_mode_i = 1'b0;
        i_host.read(16'h0129, d, n);
        check(16'(n), 16'd8, "answer outside query mode");
        query_mode_i = 1'b1;
    endtask : t_refused

    initial begin
        sys_clk_i = 1'b0;
        resetn_i = 1'b0;
        query_mode_i = 1'b1;
        mux_strap_i = 1'b0;
        err_total = 0;
        checks_done = 0;
        do_reset(1'b0);
        t_table_sweep(1'b0);
        t_outside();
        t_refused();
        do_reset(1'b1);
        t_table_sweep(1'b1);
        finish_test();
    end

    // Whole run needs about 180 cycles
    initial begin
        #50000;
        err_total++;
        $display("FAIL %0t watchdog expired", $time);
        finish_test();
    end
endmodule : testbench
